// ### verilog/pll_clock_control.sv
// Clock source selection, a protected clock control register and settle timing.
//
// How it works
// - No interrupt sampled right after a non-sampling instruction.
// - Irq enable/disable, status-word load, command writes.
// - PLL is off after reset.
// - Oscillator restart starts a settle interval.
// - Clock delivery frozen while the timer counts.
// - Clock control: bit7 PLL on, bit5 select.
// - Illegal control store sets protection error flag.
// - Clock control takes byte and bit accesses.
// - PLL off selects the oscillator clock directly.
// - PLL on switches over once lock is reached.
// - Count lengths follow select bit and release kind.
// - Divider select picks times four or two.
// - Divider: bit0 select, other bits read zero.
// - Divider takes byte and bit accesses.
`timescale 1ns/10ps
`default_nettype none
module pll_clock_control #(
    parameter int unsigned WATCH_SHORT = pll_clock_pkg::WATCH_SHORT_CYCLES, // Cycles.
    parameter int unsigned WATCH_LONG  = pll_clock_pkg::WATCH_LONG_CYCLES,  // Cycles.
    parameter int unsigned STOP_SHORT  = pll_clock_pkg::STOP_SHORT_CYCLES,  // Cycles.
    parameter int unsigned STOP_LONG   = pll_clock_pkg::STOP_LONG_CYCLES    // Cycles.
) (
    input  wire logic                sys_clk,
    input  wire logic                reset,
    input  wire logic [31:0]         busAddr,
    input  wire logic                busWrite,
    input  wire logic                busRead,
    input  wire logic                busBitAccess,
    input  wire logic [2:0]          busBitIndex,
    input  wire logic [7:0]          busWrData,
    output logic [7:0]               busRdData,
    output logic                     busRdValid,
    input  wire logic                instrDone,
    input  wire logic                instrIrqEnable,
    input  wire logic                instrIrqDisable,
    input  wire logic                instrSysRegLoad,
    input  wire logic [4:0]          sysRegNum,
    input  wire logic                watchRelease,
    input  wire logic                stopRelease,
    input  wire logic                pllLocked,
    output logic                     pllPowerOn,
    output var pll_clock_pkg::clk_src_t clkSource,
    output logic                     clockHold,
    output logic                     irqSampleBlock,
    output logic                     protectError
);
    import pll_clock_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    ctrl_state_t st_ff;        // Registered control state.
    ctrl_state_t nxt_st;       // Next control state.
    settle_if    settle ();    // Link to the settle timer.

    logic        anyAccess;    // Any read or write on the bus this cycle.
    logic        hitControl;   // Address hits clock control.
    logic        hitDivide;    // Address hits the divider.
    logic        hitStatus;    // Address hits protection status.
    logic        hitPrimary;   // Address hits the primary command.
    logic        hitSecondary; // Address hits the secondary command.
    logic        cmdByteWrite; // Byte write to either command register.
    logic        nonSampling;  // A non-sampling instruction this cycle.
    logic [7:0]  controlView;  // Clock control as read.
    logic [7:0]  divideView;   // Divider as read.
    logic [7:0]  statusView;   // Status as read.
    logic [7:0]  controlNew;   // Clock control after a write.
    logic [7:0]  divideNew;    // Divider after a write.
    logic [7:0]  statusNew;    // Status after a write.

    // Long counts are parameters so that simulation can shorten them.
    localparam logic [SETTLE_W-1:0] WATCH_SHORT_V = WATCH_SHORT[SETTLE_W-1:0];
    localparam logic [SETTLE_W-1:0] WATCH_LONG_V  = WATCH_LONG[SETTLE_W-1:0];
    localparam logic [SETTLE_W-1:0] STOP_SHORT_V  = STOP_SHORT[SETTLE_W-1:0];
    localparam logic [SETTLE_W-1:0] STOP_LONG_V   = STOP_LONG[SETTLE_W-1:0];

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // Only exact byte addresses match; everything else reads as zero.
    always_comb begin
        anyAccess    = busWrite | busRead;
        hitControl   = (busAddr == ADDR_CLOCK_SOURCE_CONTROL);
        hitDivide    = (busAddr == ADDR_PLL_DIVIDE_SELECT);
        hitStatus    = (busAddr == ADDR_PROTECT_STATUS_REGISTER);
        hitPrimary   = (busAddr == ADDR_PRIMARY_PROTECT_COMMAND);
        hitSecondary = (busAddr == ADDR_SECONDARY_PROTECT_COMMAND);
        cmdByteWrite = busWrite & ~busBitAccess & (hitPrimary | hitSecondary);
    end

    // ------------------------------------------------------------------
    // Read views and write merging
    // ------------------------------------------------------------------
    // Unused control bits and the upper divider bits are constant zero,
    // so a write of one there is simply dropped.
    always_comb begin
        controlView                 = CLOCK_CONTROL_RESET;
        controlView[PLL_ON_BIT]     = st_ff.pllOn;
        controlView[SETTLE_SEL_BIT] = st_ff.settleSel;
        divideView                  = DIVIDE_RESET;
        divideView[HALVE_SEL_BIT]   = st_ff.halveSel;
        statusView                  = STATUS_RESET;
        statusView[PROTECT_ERR_BIT] = st_ff.protectErr;
        // A bit access changes one bit and keeps the others.
        controlNew = busWrData;
        divideNew  = busWrData;
        statusNew  = busWrData;
        if (busBitAccess) begin
            controlNew              = controlView;
            controlNew[busBitIndex] = busWrData[0];
            divideNew               = divideView;
            divideNew[busBitIndex]  = busWrData[0];
            statusNew               = statusView;
            statusNew[busBitIndex]  = busWrData[0];
        end
    end

    // ------------------------------------------------------------------
    // Non-sampling instruction detection
    // ------------------------------------------------------------------
    // The protect-command stores are seen on the bus, the others are
    // reported by the core as they complete.
    always_comb begin
        nonSampling = instrIrqEnable | instrIrqDisable | cmdByteWrite
                    | (instrSysRegLoad & (sysRegNum == STATUS_WORD_REG));
    end

    // ------------------------------------------------------------------
    // Settle timer start
    // ------------------------------------------------------------------
    // STOP release takes priority if both arrive together, because its
    // interval is the longer and therefore the safer one.
    always_comb begin
        settle.load      = watchRelease | stopRelease;
        settle.loadValue = WATCH_SHORT_V;
        if (stopRelease) begin
            settle.loadValue = st_ff.settleSel ? STOP_LONG_V : STOP_SHORT_V;
        end else if (watchRelease) begin
            settle.loadValue = st_ff.settleSel ? WATCH_LONG_V : WATCH_SHORT_V;
        end
    end

    // ------------------------------------------------------------------
    // Next control state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st         = st_ff;
        nxt_st.rdValid = busRead;
        nxt_st.rdData  = '0;

        // Reads answer on the next edge.
        if (busRead) begin
            if (hitControl) begin
                nxt_st.rdData = controlView;
            end else if (hitDivide) begin
                nxt_st.rdData = divideView;
            end else if (hitStatus) begin
                nxt_st.rdData = statusView;
            end
        end

        // The unlock lasts for exactly the one access after the command.
        if (anyAccess) begin
            nxt_st.armed = 1'b0;
        end
        if (busWrite & ~busBitAccess & hitPrimary) begin
            nxt_st.armed = 1'b1;
        end

        // Clock control is only written when unlocked.
        if (busWrite & hitControl) begin
            if (st_ff.armed) begin
                nxt_st.pllOn     = controlNew[PLL_ON_BIT];
                nxt_st.settleSel = controlNew[SETTLE_SEL_BIT];
            end
        end

        // Divider write, unprotected.
        if (busWrite & hitDivide) begin
            nxt_st.halveSel = divideNew[HALVE_SEL_BIT];
        end

        // Software clears the error by writing zero; a new error in the
        // same cycle wins so that no violation is lost.
        if (busWrite & hitStatus & ~statusNew[PROTECT_ERR_BIT]) begin
            nxt_st.protectErr = 1'b0;
        end
        if (busWrite & hitControl & ~st_ff.armed) begin
            nxt_st.protectErr = 1'b1;
        end

        // Hold off sampling until the next instruction has completed.
        if (nonSampling) begin
            nxt_st.irqBlock = 1'b1;
        end else if (instrDone) begin
            nxt_st.irqBlock = 1'b0;
        end

        // Clock source follows the enable and lock, never jumping to an
        // unlocked PLL output.
        unique case (st_ff.clkSrc)
            SRC_DIRECT: begin
                if (st_ff.pllOn & pllLocked) begin
                    nxt_st.clkSrc = st_ff.halveSel ? SRC_PLL_X2 : SRC_PLL_X4;
                end
            end
            SRC_PLL_X4, SRC_PLL_X2: begin
                if (~st_ff.pllOn | ~pllLocked) begin
                    nxt_st.clkSrc = SRC_DIRECT;
                end else begin
                    nxt_st.clkSrc = st_ff.halveSel ? SRC_PLL_X2 : SRC_PLL_X4;
                end
            end
            default: begin
                nxt_st.clkSrc = SRC_DIRECT;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset brings the PLL up switched off and the oscillator selected.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_ff        <= '0;
            st_ff.clkSrc <= SRC_DIRECT;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Settle timer
    // ------------------------------------------------------------------
    // The timer is its own small block so that its wide counter is kept
    // apart from the register logic.
    settle_timer u_settle_timer (
        .sys_clk (sys_clk),
        .reset   (reset),
        .tmr     (settle)
    );

    // ------------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ------------------------------------------------------------------
    assign busRdData      = st_ff.rdData;
    assign busRdValid     = st_ff.rdValid;
    assign pllPowerOn     = st_ff.pllOn;
    assign clkSource      = st_ff.clkSrc;
    assign clockHold      = settle.busy;
    assign irqSampleBlock = st_ff.irqBlock;
    assign protectError   = st_ff.protectErr;

endmodule : pll_clock_control
`default_nettype wire

// ### verilog/pll_clock_pkg.sv
// Shared constants, types and state layouts of the clock generator control block.
package pll_clock_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_CLOCK_SOURCE_CONTROL      = 32'hfffff822; // Clock control.
    localparam logic [31:0] ADDR_PLL_DIVIDE_SELECT         = 32'hfffff842; // PLL divider.
    localparam logic [31:0] ADDR_PRIMARY_PROTECT_COMMAND   = 32'hfffff800; // Unlocks control.
    localparam logic [31:0] ADDR_SECONDARY_PROTECT_COMMAND = 32'hfffff1fc; // Second command.
    localparam logic [31:0] ADDR_PROTECT_STATUS_REGISTER   = 32'hfffff802; // Error status.

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int unsigned PLL_ON_BIT          = 7;      // PLL enable in clock control.
    localparam int unsigned SETTLE_SEL_BIT      = 5;      // Count length select.
    localparam int unsigned HALVE_SEL_BIT       = 0;      // Divide-by-2 select.
    localparam int unsigned PROTECT_ERR_BIT     = 0;      // Error flag in status.
    localparam logic [7:0]  CLOCK_CONTROL_RESET = 8'h00;  // Clock control after reset.
    localparam logic [7:0]  DIVIDE_RESET        = 8'h00;  // Divider after reset.
    localparam logic [7:0]  STATUS_RESET        = 8'h00;  // Status after reset.
    localparam logic [4:0]  STATUS_WORD_REG     = 5'h05;  // System register of the status word.

    // ------------------------------------------------------------------
    // Timing: counts are in oscillator periods, converted to sys_clk cycles
    // ------------------------------------------------------------------
    localparam int unsigned OSC_PERIOD_NS        = 40;     // Oscillator clock period.
    localparam int unsigned SYS_CLK_PERIOD_NS    = 40;     // Period of sys_clk.
    localparam int unsigned WATCH_SHORT_PERIODS  = 5300;   // WATCH release, short select.
    localparam int unsigned WATCH_LONG_PERIODS   = 10600;  // WATCH release, long select.
    localparam int unsigned STOP_SHORT_PERIODS   = 50300;  // STOP release, short select.
    localparam int unsigned STOP_LONG_PERIODS    = 100600; // STOP release, long select.
    localparam int unsigned WATCH_SHORT_CYCLES   =
        (WATCH_SHORT_PERIODS * OSC_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned WATCH_LONG_CYCLES    =
        (WATCH_LONG_PERIODS * OSC_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned STOP_SHORT_CYCLES    =
        (STOP_SHORT_PERIODS * OSC_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned STOP_LONG_CYCLES     =
        (STOP_LONG_PERIODS * OSC_PERIOD_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
    localparam int unsigned SETTLE_W             = 17;     // Holds the longest count.

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    // System clock source as steered to the clock tree.
    typedef enum logic [1:0] {
        SRC_DIRECT,
        SRC_PLL_X4,
        SRC_PLL_X2
    } clk_src_t;

    // Whole state of the control module.
    typedef struct packed {
        logic       pllOn;       // PLL enable bit.
        logic       settleSel;   // Long count select bit.
        logic       halveSel;    // Divide-by-2 select bit.
        logic       protectErr;  // Sticky protection error.
        logic       armed;       // Primary command just written.
        logic       irqBlock;    // Interrupt sampling held off.
        logic [7:0] rdData;      // Read answer.
        logic       rdValid;     // Read answer strobe.
        clk_src_t   clkSrc;      // Selected clock source.
    } ctrl_state_t;

    // Whole state of the settle timer.
    typedef struct packed {
        logic [SETTLE_W-1:0] remain; // Cycles still to hold.
        logic                busy;   // Clock delivery frozen.
    } timer_state_t;

endpackage : pll_clock_pkg

// ### verilog/settle_if.sv
// Connection between the clock control logic and its settle timer.
`timescale 1ns/10ps
`default_nettype none
interface settle_if;
    import pll_clock_pkg::*;

    logic                load;      // One-cycle start pulse.
    logic [SETTLE_W-1:0] loadValue; // Cycles to hold, at least one.
    logic                busy;      // Timer still counting.

    modport ctrl  (output load, output loadValue, input busy);
    modport timer (input load, input loadValue, output busy);
endinterface : settle_if
`default_nettype wire

// ### verilog/settle_timer.sv
// Down-counter that freezes clock delivery for a loaded number of cycles.
`timescale 1ns/10ps
`default_nettype none
module settle_timer (
    input  wire logic sys_clk,
    input  wire logic reset,
    settle_if.timer   tmr
);
    import pll_clock_pkg::*;

    timer_state_t st_ff;   // Registered timer state.
    timer_state_t nxt_st;  // Next timer state.

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // A new load restarts the count from the new value, so a second release
    // can cut short or extend the interval that the first one began.
    always_comb begin
        nxt_st = st_ff;
        if (tmr.load) begin
            nxt_st.remain = tmr.loadValue;
            nxt_st.busy   = 1'b1;
        end else if (st_ff.remain != '0) begin
            nxt_st.remain = st_ff.remain - 1'b1;
            nxt_st.busy   = (st_ff.remain != {{(SETTLE_W-1){1'b0}}, 1'b1});
        end else begin
            nxt_st.busy = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Reset leaves the clock running freely.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tmr.busy = st_ff.busy; // Straight from the flip-flop.

endmodule : settle_timer
`default_nettype wire

// ### tb/pll_clock_control_chk.sv
// Port-level assertion checker of the clock control block.
`timescale 1ns/10ps
`default_nettype none
module pll_clock_control_chk
    import pll_clock_pkg::*;
#(
    parameter int unsigned WATCH_SHORT = 5,
    parameter int unsigned WATCH_LONG  = 10,
    parameter int unsigned STOP_SHORT  = 50,
    parameter int unsigned STOP_LONG   = 100
) (
    input wire logic        sys_clk,
    input wire logic        reset,
    input wire logic [31:0] busAddr,
    input wire logic        busWrite,
    input wire logic        busRead,
    input wire logic        busBitAccess,
    input wire logic [7:0]  busWrData,
    input wire logic        busRdValid,
    input wire logic        instrIrqEnable,
    input wire logic        instrIrqDisable,
    input wire logic        instrSysRegLoad,
    input wire logic [4:0]  sysRegNum,
    input wire logic        watchRelease,
    input wire logic        stopRelease,
    input wire logic        pllLocked,
    input wire logic        pllPowerOn,
    input var  clk_src_t    clkSource,
    input wire logic        clockHold,
    input wire logic        irqSampleBlock,
    input wire logic        protectError
);
    logic armedChk; // Unlock as the checker sees it.
    int   holdCnt;  // Cycles held so far.
    wire logic ctlWr = busWrite && busAddr == ADDR_CLOCK_SOURCE_CONTROL;
    wire logic cmdWr = busWrite && !busBitAccess && (busAddr == ADDR_PRIMARY_PROTECT_COMMAND
                       || busAddr == ADDR_SECONDARY_PROTECT_COMMAND);

    // Any access consumes the unlock.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            armedChk <= 1'b0;
            holdCnt  <= 0;
        end else begin
            if (busWrite || busRead) begin
                armedChk <= busWrite && !busBitAccess && busAddr == ADDR_PRIMARY_PROTECT_COMMAND;
            end
            if (watchRelease || stopRelease) begin
                holdCnt <= 0;
            end else if (clockHold) begin
                holdCnt <= holdCnt + 1;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    a_reset_pll_off: assert property ($fell(reset) |-> !pllPowerOn && !clockHold)
        else $error("Active after reset");
    a_direct_when_off: assert property (!pllPowerOn |=> clkSource == SRC_DIRECT)
        else $error("PLL source while off");
    a_unlocked_direct: assert property (!pllLocked |=> clkSource == SRC_DIRECT)
        else $error("PLL source before lock");
    a_locked_switch: assert property (pllPowerOn && pllLocked && !busWrite |=>
        clkSource != SRC_DIRECT)
        else $error("No switch after lock");
    a_release_hold: assert property (watchRelease || stopRelease |=> clockHold)
        else $error("No hold after restart");
    a_hold_length: assert property ($fell(clockHold) |->
        holdCnt inside {WATCH_SHORT, WATCH_LONG, STOP_SHORT, STOP_LONG})
        else $error("Bad hold length");
    a_nonsample_block: assert property (instrIrqEnable || instrIrqDisable || cmdWr
        || (instrSysRegLoad && sysRegNum == STATUS_WORD_REG) |=> irqSampleBlock)
        else $error("Sampling not blocked");
    a_read_answer: assert property (busRead |=> busRdValid)
        else $error("Read not answered");
    a_guarded_store: assert property (ctlWr && !armedChk |=>
        protectError && $stable(pllPowerOn))
        else $error("Unguarded store took effect");
    a_unlocked_store: assert property (ctlWr && armedChk && !busBitAccess && busWrData[7]
        |=> pllPowerOn)
        else $error("Guarded store ignored");
endmodule : pll_clock_control_chk
`default_nettype wire

// ### tb/pll_lock_model.sv
// Behavioural analog PLL that reports lock a fixed time after power-up.
`timescale 1ns/10ps
`default_nettype none
module pll_lock_model #(
    parameter int unsigned LOCK_CYCLES = 20 // Lock-up time in cycles.
) (
    input  wire logic sys_clk,
    input  wire logic powerOn,
    output logic      pllLocked
);
    int unsigned lockCnt; // Cycles since power-up.

    // Lock drops on the first edge after power-down, so a stale lock never leaks through.
    always_ff @(posedge sys_clk) begin
        if (!powerOn) begin
            lockCnt   <= 0;
            pllLocked <= 1'b0;
        end else begin
            lockCnt   <= (lockCnt < LOCK_CYCLES) ? lockCnt + 1 : lockCnt;
            pllLocked <= lockCnt >= LOCK_CYCLES;
        end
    end
endmodule : pll_lock_model
`default_nettype wire

// ### tb/test_pll_clock_control.sv
// Self-checking bench of the clock control block.
`timescale 1ns/10ps
`default_nettype none
module test_pll_clock_control;
    import pll_clock_pkg::*;
    localparam int unsigned WS = 5, WL = 10, SS = 50, SL = 100; // Shortened counts.
    localparam logic [31:0] CTL = ADDR_CLOCK_SOURCE_CONTROL, DIV = ADDR_PLL_DIVIDE_SELECT;
    localparam logic [31:0] PRI = ADDR_PRIMARY_PROTECT_COMMAND, STS = ADDR_PROTECT_STATUS_REGISTER;
    logic sys_clk, reset, busWrite, busRead, busBitAccess, busRdValid, instrDone;
    logic instrIrqEnable, instrIrqDisable, instrSysRegLoad, watchRelease, stopRelease;
    logic pllLocked, pllPowerOn, clockHold, irqSampleBlock, protectError;
    logic [31:0] busAddr;
    logic [7:0]  busWrData, busRdData;
    logic [2:0]  busBitIndex;
    logic [4:0]  sysRegNum;
    clk_src_t    clkSource;
    int failures, nCompared;
    int unsigned holdExp[3] = '{WL, SL, SS}; // Watch long, stop long, stop short.

    pll_clock_control #(.WATCH_SHORT(WS), .WATCH_LONG(WL), .STOP_SHORT(SS), .STOP_LONG(SL))
    i_dut (.sys_clk, .reset, .busAddr, .busWrite, .busRead, .busBitAccess, .busBitIndex,
        .busWrData, .busRdData, .busRdValid, .instrDone, .instrIrqEnable, .instrIrqDisable,
        .instrSysRegLoad, .sysRegNum, .watchRelease, .stopRelease, .pllLocked, .pllPowerOn,
        .clkSource, .clockHold, .irqSampleBlock, .protectError);
    pll_lock_model i_pll (.sys_clk, .powerOn(pllPowerOn), .pllLocked);

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask : tick
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp8
    task automatic cmpSrc(input clk_src_t got, input clk_src_t exp);
        cmp8({6'h00, got}, {6'h00, exp}, "clock source");
    endtask : cmpSrc
    // Signals stand until the next call.
    task automatic acc(input logic w, r, b, input logic [31:0] a, input logic [7:0] d,
                       input logic [2:0] i);
        {busWrite, busRead, busBitAccess, busAddr, busWrData, busBitIndex} = {w, r, b, a, d, i};
        tick();
    endtask : acc
    task automatic idle();
        {busWrite, busRead} = 2'b00;
        tick();
    endtask : idle
    task automatic wr(input logic [31:0] a, input logic b, input logic [2:0] i,
                      input logic [7:0] d);
        acc(1'b1, 1'b0, b, a, d, i);
        idle();
    endtask : wr
    // Unlocked control store.
    task automatic guarded(input logic b, input logic [2:0] i, input logic [7:0] d);
        acc(1'b1, 1'b0, 1'b0, PRI, 8'h00, 3'h0);
        wr(CTL, b, i, d);
    endtask : guarded
    task automatic rd(input logic [31:0] a, input logic [7:0] exp);
        acc(1'b0, 1'b1, 1'b0, a, 8'h00, 3'h0);
        cmp8({7'h00, busRdValid}, 8'h01, "read strobe");
        cmp8(busRdData, exp, "read data");
        idle();
    endtask : rd
    task automatic hold(input logic stop, input int unsigned exp);
        int unsigned n;
        {watchRelease, stopRelease} = {!stop, stop};
        tick();
        {watchRelease, stopRelease} = 2'b00;
        n = 0;
        while (clockHold === 1'b1 && n < 300) begin
            n++;
            tick();
        end
        cmp8(8'(n), 8'(exp), "hold length");
    endtask : hold
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    // A hang is a mismatch too.
    initial begin
        repeat (3000) @(posedge sys_clk);
        failures++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        give_verdict();
    end

    initial begin
        {busWrite, busRead, busBitAccess, busAddr, busWrData, busBitIndex} = '0;
        {instrDone, instrIrqEnable, instrIrqDisable, instrSysRegLoad, sysRegNum} = '0;
        {watchRelease, stopRelease} = '0;
        reset = 1'b1;
        repeat (16) tick();
        reset = 1'b0;
        rd(CTL, CLOCK_CONTROL_RESET);
        rd(DIV, DIVIDE_RESET);
        cmp8({7'h00, pllPowerOn}, 8'h00, "PLL power");
        cmpSrc(clkSource, SRC_DIRECT);
        wr(CTL, 1'b0, 3'h0, 8'ha0);
        rd(CTL, 8'h00);
        rd(STS, 8'h01);
        wr(STS, 1'b0, 3'h0, 8'h00);
        acc(1'b1, 1'b0, 1'b0, PRI, 8'h00, 3'h0);
        acc(1'b0, 1'b1, 1'b0, CTL, 8'h00, 3'h0);
        wr(CTL, 1'b0, 3'h0, 8'h80);
        rd(STS, 8'h01);
        wr(STS, 1'b0, 3'h0, 8'h00);
        wr(DIV, 1'b0, 3'h0, 8'hff);
        rd(DIV, 8'h01);
        wr(DIV, 1'b1, 3'h0, 8'h00);
        rd(DIV, 8'h00);
        guarded(1'b0, 3'h0, 8'hff);
        cmp8({7'h00, irqSampleBlock}, 8'h01, "block after command");
        rd(CTL, 8'ha0);
        for (int h = 0; h < 2; h++) begin
            guarded(1'b1, 3'h7, 8'h00);
            tick();
            cmpSrc(clkSource, SRC_DIRECT);
            wr(DIV, 1'b1, 3'h0, 8'(h));
            guarded(1'b1, 3'h7, 8'h01);
            for (int n = 0; n < 100 && clkSource === SRC_DIRECT; n++) tick();
            cmpSrc(clkSource, h == 1 ? SRC_PLL_X2 : SRC_PLL_X4);
        end
        for (int k = 0; k < 3; k++) begin
            if (k == 2) guarded(1'b1, 3'h5, 8'h00);
            hold(k != 0, holdExp[k]);
        end
        for (int j = 0; j < 4; j++) begin
            {instrIrqEnable, instrIrqDisable, instrSysRegLoad} = {j == 0, j == 1, j >= 2};
            sysRegNum = (j == 2) ? STATUS_WORD_REG : 5'h04;
            tick();
            {instrIrqEnable, instrIrqDisable, instrSysRegLoad} = '0;
            cmp8({7'h00, irqSampleBlock}, {7'h00, j != 3}, "sampling block");
            instrDone = 1'b1;
            tick();
            instrDone = 1'b0;
            repeat (2) tick();
            cmp8({7'h00, irqSampleBlock}, 8'h00, "block release");
        end
        give_verdict();
    end
endmodule : test_pll_clock_control

bind pll_clock_control pll_clock_control_chk #(.WATCH_SHORT(WATCH_SHORT),
    .WATCH_LONG(WATCH_LONG), .STOP_SHORT(STOP_SHORT), .STOP_LONG(STOP_LONG)) i_chk (
    .sys_clk, .reset, .busAddr, .busWrite, .busRead, .busBitAccess, .busWrData, .busRdValid,
    .instrIrqEnable, .instrIrqDisable, .instrSysRegLoad, .sysRegNum, .watchRelease,
    .stopRelease, .pllLocked, .pllPowerOn, .clkSource, .clockHold, .irqSampleBlock,
    .protectError);
`default_nettype wire
